// ---- design/cache_partition_victim_filter.sv ----
// Victim selection and allocation filter for a partitioned set-associative cache.
// Assumes requesters on the same clock, one request per cycle, NUM_WAYS a power of two.
// Limitation: occupancy moves only on installs; a line never leaves except by replacement.
`timescale 1ns/100ps
module cache_partition_victim_filter
	import cache_partition_victim_filter_pkg::*;
#(
	parameter int NUM_PARTITIONS = 4,
	parameter int NUM_SETS       = 16,
	parameter int NUM_WAYS       = 8,
	parameter int NUM_PORTIONS   = 4,
	parameter int TAG_W          = 12,
	parameter int CAP_WD         = 8,
	parameter int ASSOC_WD       = 8
) (
	input  wire logic                              i_sys_clk,
	input  wire logic                              i_rst,
	input  wire logic [7:0]                        i_reg_addr,
	input  wire logic [31:0]                       i_reg_wdata,
	input  wire logic                              i_reg_wr,
	input  wire logic                              i_reg_rd,
	output logic      [31:0]                       o_reg_rdata,
	input  wire logic                              i_req_valid,
	input  wire logic [$clog2(NUM_PARTITIONS)-1:0] i_req_partition,
	input  wire logic [$clog2(NUM_SETS)-1:0]       i_req_set,
	input  wire logic [TAG_W-1:0]                  i_req_tag,
	output logic                                   o_resp_valid,
	output logic                                   o_resp_hit,
	output logic                                   o_resp_alloc,
	output logic      [$clog2(NUM_WAYS)-1:0]       o_resp_way,
	output logic      [2:0]                        o_resp_priority,
	output logic                                   o_resp_evict,
	output logic      [$clog2(NUM_PARTITIONS)-1:0] o_resp_evict_partition
);

	localparam int PART_W      = $clog2(NUM_PARTITIONS);
	localparam int SET_W       = $clog2(NUM_SETS);
	localparam int WAY_W       = $clog2(NUM_WAYS);
	localparam int TOTAL_LINES = NUM_SETS * NUM_WAYS;
	localparam int OCC_W       = $clog2(TOTAL_LINES + 1);
	localparam int CMP_W       = OCC_W + FRAC_W + 1;
	localparam int WAYS_PER_PORTION = NUM_WAYS / NUM_PORTIONS;

	// Only the top fraction bits exist; the rest read zero and drop writes
	localparam logic [15:0] CAP_MASK   = 16'(16'hFFFF << (FRAC_W - CAP_WD));
	localparam logic [15:0] ASSOC_MASK = 16'(16'hFFFF << (FRAC_W - ASSOC_WD));

	// Configuration, one entry per partition except the single shared partition_select
	logic [PART_W-1:0]       partition_select;
	logic [15:0]             min_capacity_fraction [NUM_PARTITIONS];
	logic [15:0]             max_capacity_fraction [NUM_PARTITIONS];
	logic [15:0]             max_associativity_fraction [NUM_PARTITIONS];
	logic                    soft_limit_bit [NUM_PARTITIONS];
	logic [NUM_PORTIONS-1:0] portion_allow_bitmap [NUM_PARTITIONS];
	logic                    partition_enable [NUM_PARTITIONS];
	logic [OCC_W-1:0]        occupancy [NUM_PARTITIONS];

	// Line state
	logic                    line_valid [NUM_SETS][NUM_WAYS];
	logic [PART_W-1:0]       line_owner [NUM_SETS][NUM_WAYS];
	logic [TAG_W-1:0]        line_tag   [NUM_SETS][NUM_WAYS];
	logic [WAY_W-1:0]        replace_ptr [NUM_SETS];

	// Fraction compare: count/total against frac/2^16, scaled to integers
	function automatic logic [CMP_W-1:0] scaled_use(input logic [OCC_W-1:0] count);
		scaled_use = CMP_W'({count, 16'h0000});
	endfunction : scaled_use

	// One spare bit keeps the product from wrapping at the largest fraction
	function automatic logic [CMP_W-1:0] scaled_frac(input logic [15:0] frac, input int units);
		scaled_frac = CMP_W'(frac) * CMP_W'(units);
	endfunction : scaled_frac

	function automatic logic over_max(input logic [PART_W-1:0] p);
		over_max = scaled_use(occupancy[p]) > scaled_frac(max_capacity_fraction[p], TOTAL_LINES);
	endfunction : over_max

	function automatic logic under_min(input logic [PART_W-1:0] p);
		under_min = scaled_use(occupancy[p]) < scaled_frac(min_capacity_fraction[p], TOTAL_LINES);
	endfunction : under_min

	// A valid line in the addressed set that the requester already owns
	function automatic logic owned(input int w);
		owned = line_valid[i_req_set][w] && line_owner[i_req_set][w] == i_req_partition;
	endfunction : owned

	// Maximum is tested first so the minimum never lifts an over-limit partition
	function automatic logic [2:0] partition_priority(input logic [PART_W-1:0] p);
		if (!partition_enable[p]) begin
			partition_priority = PRIO_DISABLED;
		end else if (over_max(p)) begin
			partition_priority = PRIO_OVER_MAX;
		end else if (under_min(p)) begin
			partition_priority = PRIO_UNDER_MIN;
		end else begin
			partition_priority = PRIO_MIDRANGE;
		end
	endfunction : partition_priority

	// Request evaluation
	logic [2:0]          req_prio;
	logic                req_over;
	logic                assoc_full;
	logic [WAY_W:0]      own_ways;
	logic [NUM_WAYS-1:0] hit_vec;
	logic [NUM_WAYS-1:0] cand_vec;
	logic [NUM_WAYS-1:0] final_vec;
	logic [2:0]          line_prio [NUM_WAYS];
	logic [2:0]          min_prio;
	logic                hit;
	logic [WAY_W-1:0]    hit_way;
	logic                found;
	logic [WAY_W-1:0]    victim;
	logic [WAY_W-1:0]    probe;
	logic                do_alloc;

	always_comb begin
		req_prio = partition_priority(i_req_partition);
		req_over = over_max(i_req_partition);
		own_ways = '0;
		hit      = 1'b0;
		hit_way  = '0;
		min_prio = PRIO_UNDER_MIN;
		probe    = '0;
		for (int w = 0; w < NUM_WAYS; w++) begin
			if (owned(w)) begin
				own_ways = own_ways + 1'b1;
			end
			// Lookup ignores the owner entirely
			hit_vec[w] = line_valid[i_req_set][w] && line_tag[i_req_set][w] == i_req_tag;
			if (hit_vec[w] && !hit) begin
				hit     = 1'b1;
				hit_way = WAY_W'(w);
			end
		end
		// Binary point sits above bit 15, so ways * frac / 2^16 is the share
		assoc_full = scaled_use(OCC_W'(own_ways)) >
			scaled_frac(max_associativity_fraction[i_req_partition], NUM_WAYS);
		// Controls first, then tier pruning, then round-robin: a hard-limited request
		// must be cut down to its own lines before pruning, or a lower empty line
		// could win over the limit that forbids it new capacity.
		// Later stages only ever clear candidate bits, never set them.
		for (int w = 0; w < NUM_WAYS; w++) begin
			logic lv;
			logic own;
			lv  = line_valid[i_req_set][w];
			own = owned(w);
			// Own lines share the request's priority by construction
			line_prio[w] = lv ? partition_priority(line_owner[i_req_set][w]) : PRIO_UNALLOCATED;
			// Disabled partitions own no portions
			cand_vec[w] = partition_enable[i_req_partition] &&
				portion_allow_bitmap[i_req_partition][w / WAYS_PER_PORTION];
			if (req_over) begin
				if (soft_limit_bit[i_req_partition]) begin
					cand_vec[w] = cand_vec[w] &&
						(!lv || !partition_enable[line_owner[i_req_set][w]] || own);
				end else begin
					cand_vec[w] = cand_vec[w] && own;
				end
			end
			if (assoc_full) begin
				cand_vec[w] = cand_vec[w] && own;
			end
			if (line_prio[w] > req_prio) begin
				cand_vec[w] = 1'b0;
			end
			if (cand_vec[w] && line_prio[w] < min_prio) begin
				min_prio = line_prio[w];
			end
		end
		// Survivors are all <= request; keeping the minimum tier selects lower lines when present
		for (int w = 0; w < NUM_WAYS; w++) begin
			final_vec[w] = cand_vec[w] && line_prio[w] == min_prio;
		end
		// Round-robin per set stands in for the replacement algorithm
		found  = 1'b0;
		victim = '0;
		for (int k = 0; k < NUM_WAYS; k++) begin
			probe = WAY_W'(replace_ptr[i_req_set] + WAY_W'(k));
			if (!found && final_vec[probe]) begin
				found  = 1'b1;
				victim = probe;
			end
		end
		// A disabled requester may still hit; it only never installs
		do_alloc = i_req_valid && !hit && found;
	end

	// Line store and replacement pointer
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			for (int s = 0; s < NUM_SETS; s++) begin
				replace_ptr[s] <= '0;
				for (int w = 0; w < NUM_WAYS; w++) begin
					line_valid[s][w] <= 1'b0;
					line_owner[s][w] <= '0;
					line_tag[s][w]   <= '0;
				end
			end
		end else if (do_alloc) begin
			line_valid[i_req_set][victim] <= 1'b1;
			line_owner[i_req_set][victim] <= i_req_partition;
			line_tag[i_req_set][victim]   <= i_req_tag;
			// Pointer moves past the victim so repeated installs rotate through the set
			replace_ptr[i_req_set]        <= WAY_W'(victim + 1'b1);
		end
	end

	// Occupancy counts follow every install and eviction
	logic                evicting;
	logic [PART_W-1:0]   evict_owner;
	assign evicting    = do_alloc && line_valid[i_req_set][victim];
	assign evict_owner = line_owner[i_req_set][victim];

	// Eviction charged to partition p in this cycle
	function automatic logic evicts_from(input int p);
		evicts_from = evicting && evict_owner == PART_W'(p);
	endfunction : evicts_from

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			for (int p = 0; p < NUM_PARTITIONS; p++) begin
				occupancy[p] <= '0;
			end
		end else begin
			for (int p = 0; p < NUM_PARTITIONS; p++) begin
				// Install and eviction in one partition cancel, so no count moves twice
				if (do_alloc && i_req_partition == PART_W'(p) && !evicts_from(p)) begin
					occupancy[p] <= occupancy[p] + 1'b1;
				end else if (evicts_from(p) && i_req_partition != PART_W'(p)) begin
					occupancy[p] <= occupancy[p] - 1'b1;
				end
			end
		end
	end

	// Response
	// Way shows way 0 on a decline, since no candidate was found; only hit or alloc make it meaningful
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_resp_valid           <= 1'b0;
			o_resp_hit             <= 1'b0;
			o_resp_alloc           <= 1'b0;
			o_resp_way             <= '0;
			o_resp_priority        <= '0;
			o_resp_evict           <= 1'b0;
			o_resp_evict_partition <= '0;
		end else begin
			o_resp_valid           <= i_req_valid;
			o_resp_hit             <= i_req_valid && hit;
			o_resp_alloc           <= do_alloc;
			o_resp_way             <= hit ? hit_way : victim;
			o_resp_priority        <= req_prio;
			o_resp_evict           <= evicting;
			o_resp_evict_partition <= evict_owner;
		end
	end

	// Configuration writes
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			partition_select <= '0;
			for (int p = 0; p < NUM_PARTITIONS; p++) begin
				// Every partition comes up enabled, with a full bitmap and the widest limits
				min_capacity_fraction[p]      <= RST_MIN_FRAC & CAP_MASK;
				max_capacity_fraction[p]      <= RST_MAX_FRAC & CAP_MASK;
				max_associativity_fraction[p] <= RST_ASSOC_FRAC & ASSOC_MASK;
				soft_limit_bit[p]             <= RST_SOFT_LIMIT;
				portion_allow_bitmap[p]       <= '1;
				partition_enable[p]           <= RST_ENABLE;
			end
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				ADDR_PARTITION_SELECT: begin
					// Select only steers which partition's fields the port reaches
					partition_select <= i_reg_wdata[PART_W-1:0];
				end
				ADDR_MIN_CAPACITY: begin
					min_capacity_fraction[partition_select] <= i_reg_wdata[15:0] & CAP_MASK;
				end
				ADDR_MAX_CAPACITY: begin
					max_capacity_fraction[partition_select] <= i_reg_wdata[15:0] & CAP_MASK;
					soft_limit_bit[partition_select]        <= i_reg_wdata[SOFT_LIMIT_POS];
				end
				ADDR_ASSOCIATIVITY: begin
					max_associativity_fraction[partition_select] <= i_reg_wdata[15:0] & ASSOC_MASK;
				end
				ADDR_PORTION_BITMAP: begin
					// A new bitmap steers later installs only; placed lines drain by replacement
					portion_allow_bitmap[partition_select] <= i_reg_wdata[NUM_PORTIONS-1:0];
				end
				ADDR_PARTITION_ENABLE: begin
					partition_enable[partition_select] <= i_reg_wdata[ENABLE_POS];
				end
				default: begin
				end
			endcase
		end
	end

	// Register reads; data stands only in the cycle after the strobe
	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (i_reg_addr)
			ADDR_PARTITION_SELECT: begin
				next_rdata[PART_W-1:0] = partition_select;
			end
			ADDR_MIN_CAPACITY: begin
				next_rdata[15:0] = min_capacity_fraction[partition_select];
			end
			ADDR_MAX_CAPACITY: begin
				next_rdata[15:0]           = max_capacity_fraction[partition_select];
				next_rdata[SOFT_LIMIT_POS] = soft_limit_bit[partition_select];
			end
			ADDR_ASSOCIATIVITY: begin
				next_rdata[15:0] = max_associativity_fraction[partition_select];
			end
			ADDR_PORTION_BITMAP: begin
				next_rdata[NUM_PORTIONS-1:0] = portion_allow_bitmap[partition_select];
			end
			ADDR_PARTITION_ENABLE: begin
				next_rdata[ENABLE_POS] = partition_enable[partition_select];
			end
			ADDR_CAPACITY_FEATURE: begin
				next_rdata[FEAT_CAP_WD_POS +: 8]   = 8'(CAP_WD);
				next_rdata[FEAT_ASSOC_WD_POS +: 8] = 8'(ASSOC_WD);
			end
			ADDR_OCCUPANCY: begin
				// Live count: it may move between two reads while requests flow
				next_rdata[OCC_W-1:0] = occupancy[partition_select];
			end
			default: begin
				next_rdata = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_reg_rdata <= 32'h0000_0000;
		end else begin
			o_reg_rdata <= i_reg_rd ? next_rdata : 32'h0000_0000;
		end
	end

endmodule : cache_partition_victim_filter

// ---- design/cache_partition_victim_filter_pkg.sv ----
// Constants shared by the partitioned-cache victim filter and its bench.
// Assumes a 32-bit plain register port and 16-bit fixed-point fractions.
package cache_partition_victim_filter_pkg;

	localparam int          FRAC_W = 16;

	// Register offsets (byte addresses, one word each)
	localparam logic [7:0] ADDR_PARTITION_SELECT   = 8'h00;
	localparam logic [7:0] ADDR_MIN_CAPACITY       = 8'h04;
	localparam logic [7:0] ADDR_MAX_CAPACITY       = 8'h08;
	localparam logic [7:0] ADDR_ASSOCIATIVITY      = 8'h0C;
	localparam logic [7:0] ADDR_PORTION_BITMAP     = 8'h10;
	localparam logic [7:0] ADDR_PARTITION_ENABLE   = 8'h14;
	localparam logic [7:0] ADDR_CAPACITY_FEATURE   = 8'h18;
	localparam logic [7:0] ADDR_OCCUPANCY          = 8'h1C;

	// Field positions
	localparam int          SOFT_LIMIT_POS         = 31;
	localparam int          FEAT_CAP_WD_POS        = 0;
	localparam int          FEAT_ASSOC_WD_POS      = 8;
	localparam int          ENABLE_POS             = 0;

	// Reset values
	localparam logic [15:0] RST_MIN_FRAC           = 16'h0000;
	localparam logic [15:0] RST_MAX_FRAC           = 16'hFFFF;
	localparam logic [15:0] RST_ASSOC_FRAC         = 16'hFFFF;
	localparam logic        RST_SOFT_LIMIT         = 1'b0;
	localparam logic        RST_ENABLE             = 1'b1;

	// Allocation priority tiers
	localparam logic [2:0] PRIO_UNALLOCATED        = 3'h0;
	localparam logic [2:0] PRIO_DISABLED           = 3'h1;
	localparam logic [2:0] PRIO_OVER_MAX           = 3'h2;
	localparam logic [2:0] PRIO_MIDRANGE           = 3'h3;
	localparam logic [2:0] PRIO_UNDER_MIN          = 3'h4;

endpackage : cache_partition_victim_filter_pkg

// ---- sim/cache_partition_victim_filter_sva.sv ----
// Port-level checker for the partitioned-cache victim filter.
// Assumes the package constants; CAP_WD and ASSOC_WD come from the design through the bind.
`timescale 1ns/100ps
module cache_partition_victim_filter_sva
	import cache_partition_victim_filter_pkg::*;
#(
	parameter int CAP_WD   = 8,
	parameter int ASSOC_WD = 8
) (
	input wire logic        i_sys_clk,
	input wire logic        i_rst,
	input wire logic [7:0]  i_reg_addr,
	input wire logic        i_reg_rd,
	input wire logic [31:0] o_reg_rdata,
	input wire logic        i_req_valid,
	input wire logic        o_resp_valid,
	input wire logic        o_resp_hit,
	input wire logic        o_resp_alloc,
	input wire logic [2:0]  o_resp_priority,
	input wire logic        o_resp_evict
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	sequence s_rd(logic [7:0] a);
		i_reg_rd && i_reg_addr == a;
	endsequence

	AST_RESP_FOLLOWS: assert property (i_req_valid |=> o_resp_valid)
		else $error("response missing after request");
	AST_RESP_ONLY_ON_REQ: assert property (!i_req_valid |=> !o_resp_valid)
		else $error("response without request");
	AST_PRIO_NOT_ZERO: assert property (o_resp_valid |-> o_resp_priority inside {[PRIO_DISABLED:PRIO_UNDER_MIN]})
		else $error("request tier out of range");
	AST_HIT_XOR_ALLOC: assert property (o_resp_valid |-> !(o_resp_hit && o_resp_alloc))
		else $error("hit and allocate together");
	AST_EVICT_NEEDS_ALLOC: assert property (o_resp_evict |-> o_resp_alloc && o_resp_valid)
		else $error("eviction without allocation");
	AST_DISABLED_NO_ALLOC: assert property (o_resp_valid && o_resp_priority == PRIO_DISABLED |-> !o_resp_alloc)
		else $error("disabled partition allocated");
	AST_RDATA_IDLE: assert property (!i_reg_rd |=> o_reg_rdata == 32'h0000_0000)
		else $error("read data outside read slot");
	AST_ASSOC_LOW_ZERO: assert property (s_rd(ADDR_ASSOCIATIVITY) |=> o_reg_rdata[15-ASSOC_WD:0] == '0)
		else $error("unimplemented associativity bits set");
	AST_MIN_LOW_ZERO: assert property (s_rd(ADDR_MIN_CAPACITY) |=> o_reg_rdata[15-CAP_WD:0] == '0)
		else $error("unimplemented minimum bits set");
	AST_FEATURE_WIDTHS: assert property (s_rd(ADDR_CAPACITY_FEATURE) |=>
		o_reg_rdata[15:0] == {8'(ASSOC_WD), 8'(CAP_WD)})
		else $error("feature widths wrong");
	AST_RESET_QUIET: assert property ($fell(i_rst) |-> !o_resp_valid && o_reg_rdata == 32'h0000_0000)
		else $error("outputs active after reset");
endmodule : cache_partition_victim_filter_sva

bind cache_partition_victim_filter cache_partition_victim_filter_sva #(.CAP_WD(CAP_WD), .ASSOC_WD(ASSOC_WD)) u_sva (
	.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd),
	.o_reg_rdata(o_reg_rdata), .i_req_valid(i_req_valid), .o_resp_valid(o_resp_valid),
	.o_resp_hit(o_resp_hit), .o_resp_alloc(o_resp_alloc), .o_resp_priority(o_resp_priority),
	.o_resp_evict(o_resp_evict));

// ---- sim/cache_request_source.sv ----
// Upstream requester model issuing partition-tagged allocation requests.
// Assumes the filter takes one request per strobe and never refuses.
`timescale 1ns/100ps
module cache_request_source #(
	parameter int PART_W = 2,
	parameter int SET_W  = 4,
	parameter int TAG_W  = 12
) (
	input  wire logic              i_sys_clk,
	output logic                   o_valid,
	output logic      [PART_W-1:0] o_partition,
	output logic      [SET_W-1:0]  o_set,
	output logic      [TAG_W-1:0]  o_tag
);
	initial begin
		o_valid = 1'b0;
		o_partition = '0;
		o_set = '0;
		o_tag = '0;
	end

	// Idle fields flip so a stale value is never mistaken for a request
	task send(input logic [PART_W-1:0] p, input logic [SET_W-1:0] s, input logic [TAG_W-1:0] t);
		@(posedge i_sys_clk);
		o_valid <= 1'b1;
		o_partition <= p;
		o_set <= s;
		o_tag <= t;
		@(posedge i_sys_clk);
		o_valid <= 1'b0;
		o_partition <= ~p;
		o_set <= ~s;
		o_tag <= ~t;
	endtask : send
endmodule : cache_request_source

// ---- sim/cache_partition_victim_filter_test.sv ----
// Self-checking bench for the partitioned-cache victim filter.
// Assumes default parameters: 8 ways, 4 portions, 128 lines, 8-bit fractions.
`timescale 1ns/100ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
	$display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module cache_partition_victim_filter_test;
	import cache_partition_victim_filter_pkg::*;
	typedef struct { logic [7:0] a; logic [31:0] d; } row_t;
	logic        i_sys_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic [7:0]  addr = '0;
	logic [31:0] wdata = '0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic        req_valid, resp_valid, hit, alloc, evict;
	logic [1:0]  req_part, evict_part;
	logic [3:0]  req_set;
	logic [11:0] req_tag;
	logic [2:0]  way, prio;
	int          miscompares = 0;
	int          tests_run = 0;
	// Reset image of partition 0; last row is an unmapped place
	row_t rows [9] = '{'{ADDR_PARTITION_SELECT, 32'h0000_0000}, '{ADDR_MIN_CAPACITY, 32'h0000_0000},
		'{ADDR_MAX_CAPACITY, 32'h0000_FF00}, '{ADDR_ASSOCIATIVITY, 32'h0000_FF00},
		'{ADDR_PORTION_BITMAP, 32'h0000_000F}, '{ADDR_PARTITION_ENABLE, 32'h0000_0001},
		'{ADDR_CAPACITY_FEATURE, 32'h0000_0808}, '{ADDR_OCCUPANCY, 32'h0000_0000}, '{8'h20, 32'h0000_0000}};

	always #4 i_sys_clk = ~i_sys_clk;

	cache_request_source u_src (.i_sys_clk(i_sys_clk), .o_valid(req_valid), .o_partition(req_part),
		.o_set(req_set), .o_tag(req_tag));
	cache_partition_victim_filter dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reg_addr(addr),
		.i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_req_valid(req_valid),
		.i_req_partition(req_part), .i_req_set(req_set), .i_req_tag(req_tag), .o_resp_valid(resp_valid),
		.o_resp_hit(hit), .o_resp_alloc(alloc), .o_resp_way(way), .o_resp_priority(prio),
		.o_resp_evict(evict), .o_resp_evict_partition(evict_part));

	task close_out;
		if (miscompares == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out

	task reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge i_sys_clk);
		wr <= 1'b0;
	endtask : reg_wr

	task reg_rd(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge i_sys_clk);
		rd <= 1'b0;
		#1;
		`CHK(rdata, d)
	endtask : reg_rd

	task run_table;
		for (int k = 0; k < 9; k++)
			reg_rd(rows[k].a, rows[k].d);
	endtask : run_table

	// ha = {hit, alloc}; ev = {evict, evicted owner}
	task send(input logic [1:0] p, input logic [3:0] s, input logic [11:0] t, input logic [1:0] ha,
		input logic [2:0] w, input logic [2:0] pr, input logic [2:0] ev);
		u_src.send(p, s, t);
		#1;
		`CHK({resp_valid, hit, alloc, prio}, {1'b1, ha, pr})
		if (ha != 2'b00)
			`CHK(way, w)
		`CHK(evict, ev[2])
		if (ev[2])
			`CHK(evict_part, ev[1:0])
	endtask : send

	initial begin
		#400000;
		miscompares++;
		close_out;
	end

	initial begin
		repeat (5) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		run_table;
		for (int k = 0; k < 8; k++)
			send(2'd0, 4'd0, 12'(k + 1), 2'b01, 3'(k), PRIO_MIDRANGE, 3'b000);
		send(2'd2, 4'd0, 12'd3, 2'b10, 3'd2, PRIO_MIDRANGE, 3'b000);
		send(2'd0, 4'd0, 12'd9, 2'b01, 3'd0, PRIO_MIDRANGE, 3'b100);
		send(2'd1, 4'd0, 12'd20, 2'b01, 3'd1, PRIO_MIDRANGE, 3'b100);
		reg_rd(ADDR_OCCUPANCY, 32'h0000_0007);
		// Partition 0 climbs to the top tier; only partition 1's own way survives pruning
		reg_wr(ADDR_MIN_CAPACITY, 32'h0000_FFFF);
		send(2'd1, 4'd0, 12'd21, 2'b01, 3'd1, PRIO_MIDRANGE, 3'b101);
		reg_wr(ADDR_PARTITION_SELECT, 32'h0000_0001);
		reg_wr(ADDR_MAX_CAPACITY, 32'h0000_0000);
		// Partition 1 now over its maximum with no own line in set 1
		send(2'd1, 4'd1, 12'd5, 2'b00, 3'd0, PRIO_OVER_MAX, 3'b000);
		reg_wr(ADDR_MAX_CAPACITY, 32'h8000_0000);
		reg_rd(ADDR_MAX_CAPACITY, 32'h8000_0000);
		send(2'd1, 4'd1, 12'd5, 2'b01, 3'd0, PRIO_OVER_MAX, 3'b000);
		reg_wr(ADDR_PARTITION_SELECT, 32'h0000_0003);
		reg_wr(ADDR_PARTITION_ENABLE, 32'h0000_0000);
		send(2'd3, 4'd2, 12'd7, 2'b00, 3'd0, PRIO_DISABLED, 3'b000);
		reg_wr(ADDR_PARTITION_SELECT, 32'h0000_0002);
		reg_wr(ADDR_PORTION_BITMAP, 32'h0000_0004);
		send(2'd2, 4'd2, 12'd1, 2'b01, 3'd4, PRIO_MIDRANGE, 3'b000);
		send(2'd2, 4'd2, 12'd2, 2'b01, 3'd5, PRIO_MIDRANGE, 3'b000);
		send(2'd2, 4'd2, 12'd3, 2'b01, 3'd4, PRIO_MIDRANGE, 3'b110);
		reg_wr(ADDR_ASSOCIATIVITY, 32'h1234_ABCD);
		reg_rd(ADDR_ASSOCIATIVITY, 32'h0000_AB00);
		// One eighth share: two own ways exceed it, so empty ways are off limits
		reg_wr(ADDR_PORTION_BITMAP, 32'h0000_000F);
		reg_wr(ADDR_ASSOCIATIVITY, 32'h0000_2000);
		send(2'd2, 4'd2, 12'd4, 2'b01, 3'd5, PRIO_MIDRANGE, 3'b110);
		@(posedge i_sys_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		run_table;
		reg_wr(ADDR_MIN_CAPACITY, 32'h0000_FFFF);
		reg_rd(ADDR_MIN_CAPACITY, 32'h0000_FF00);
		send(2'd0, 4'd5, 12'd1, 2'b01, 3'd0, PRIO_UNDER_MIN, 3'b000);
		// Under its minimum yet over its maximum: the maximum decides the tier
		reg_wr(ADDR_MAX_CAPACITY, 32'h0000_0000);
		send(2'd0, 4'd5, 12'd2, 2'b01, 3'd0, PRIO_OVER_MAX, 3'b100);
		close_out;
	end
endmodule : cache_partition_victim_filter_test
